/* File: common/prot_boot_defines.svh */
// Offsets, field positions, reset values and codes of the protection and boot registers
`ifndef PROT_BOOT_DEFINES_SVH
`define PROT_BOOT_DEFINES_SVH

// Register byte offsets
`define OFS_PWD_LO      8'h00
`define OFS_PWD_HI      8'h04
`define OFS_OPTION      8'h08
`define OFS_CFG1        8'h0C
`define OFS_GUARD       8'h10
`define OFS_PVIEW       8'h14
`define OFS_DVIEW       8'h18
`define OFS_CMD         8'h1C
`define OFS_BOOT        8'h20

// Field positions
`define POS_PWD_MODE    2
`define POS_GUARD       0
`define POS_CMD_LSB     8
`define POS_CMD_OK      16
`define POS_BOOT_EN     0
`define POS_DLY_LSB     1
`define POS_ADR_LSB     9
`define CFG1_LOCK_MASK  8'hFC

// Reset values
`define RST_PWD         64'hFFFF_FFFF_FFFF_FFFF
`define RST_OPTION      16'hFFFF
`define RST_CFG1        8'h00
`define RST_VIEW        8'hFF
`define VIEW_CLEAR      8'h00
`define RST_BOOT        32'h0000_0000
`define PWD_MASKED      32'h0000_0000

// Sector commands
`define CMD_RD_PERS     3'h0
`define CMD_RD_DYN      3'h1
`define CMD_PROG_PERS   3'h2
`define CMD_ERASE_PERS  3'h3

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: common/prot_boot_pkg.sv */
// Types shared by the protection and boot register block
package prot_boot_pkg;

	// Boot read configuration word
	typedef struct packed {
		logic [22:0] start_addr;
		logic [7:0]  delay;
		logic        enable;
	} boot_cfg_t;

	// Sector command written by software
	typedef struct packed {
		logic [2:0] op;
		logic [7:0] sector;
	} sector_cmd_t;

	// Boot read sequencer states
	typedef enum logic [1:0] {
		BOOT_IDLE,
		BOOT_ARMED,
		BOOT_DELAY,
		BOOT_STREAM
	} boot_state_t;

endpackage

/* File: rtl/prot_boot_regs.sv */
// Protection and boot read register block with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "prot_boot_defines.svh"

// How it works
// - A 64-bit password is kept and reads back as a fixed masked word while password mode is on.
// - One volatile guard bit blocks changes to all persistent sector bits at once.
// - Persistent bits change only while the guard reads 1; once cleared it stays 0 until reset.
// - The persistent view byte reads FF for an unprotected last-queried sector and 00 otherwise.
// - The dynamic view byte reads FF for an unprotected last-queried sector and 00 otherwise.
// - The dynamic view is volatile and writable, both views default to all ones.
// - With boot enable set, a boot read starts as part of hardware reset; with it clear, none.
// - Bits 31 to 9 of the boot register give the boot read start address.
// - Bits 8 to 1 give the clock cycles of delay before boot data appears.
// - Password mode is on while the mode select bit of the option register is 0.
// - In password mode writes to the option register and password fail; writes to config keep the locked bits and return OKAY.
module prot_boot_regs
	import prot_boot_pkg::*;
#(
	parameter int NUM_SECTORS = 16
) (
	input  wire logic                   clk,           // 100 MHz clock
	input  wire logic                   resetn,        // Power-on reset, sync, low
	input  wire logic                   hw_reset_n,    // Hardware reset pin, async, low
	input  wire logic                   boot_cs_n,     // Chip select pin, async, low
	input  wire logic [7:0]             s_axi_awaddr,  // Write address
	input  wire logic                   s_axi_awvalid, // Write address valid
	output logic                        s_axi_awready, // Write address ready
	input  wire logic [31:0]            s_axi_wdata,   // Write data
	input  wire logic [3:0]             s_axi_wstrb,   // Write byte strobes
	input  wire logic                   s_axi_wvalid,  // Write data valid
	output logic                        s_axi_wready,  // Write data ready
	output logic [1:0]                  s_axi_bresp,   // Write response
	output logic                        s_axi_bvalid,  // Write response valid
	input  wire logic                   s_axi_bready,  // Write response ready
	input  wire logic [7:0]             s_axi_araddr,  // Read address
	input  wire logic                   s_axi_arvalid, // Read address valid
	output logic                        s_axi_arready, // Read address ready
	output logic [31:0]                 s_axi_rdata,   // Read data
	output logic [1:0]                  s_axi_rresp,   // Read response
	output logic                        s_axi_rvalid,  // Read data valid
	input  wire logic                   s_axi_rready,  // Read data ready
	output logic [22:0]                 boot_addr,     // Boot read byte address
	output logic                        boot_valid,    // Boot byte address valid
	output logic [NUM_SECTORS-1:0]      sector_wp      // Per sector write protect
);

	localparam int SW = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

	// Elaboration check on sector count
	if (NUM_SECTORS < 2 || NUM_SECTORS > 256) begin : g_bad_sectors
		$error("NUM_SECTORS must lie in 2..256");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Byte-strobe merge of a write into a word
	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Address decode shared by read and write
	function automatic logic mapped(input logic [7:0] a);
		return (a == `OFS_PWD_LO) || (a == `OFS_PWD_HI) || (a == `OFS_OPTION) ||
			(a == `OFS_CFG1) || (a == `OFS_GUARD) || (a == `OFS_PVIEW) ||
			(a == `OFS_DVIEW) || (a == `OFS_CMD) || (a == `OFS_BOOT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                   hw_meta_ff, hw_sync_ff, hw_prev_ff;
	logic                   cs_meta_ff, cs_sync_ff;
	logic                   vol_rst;
	logic                   hw_release;
	logic [63:0]            pwd_ff;
	logic [15:0]            option_ff;
	logic [7:0]             cfg1_ff;
	logic                   guard_ff;
	logic [NUM_SECTORS-1:0] pers_ff;
	logic [NUM_SECTORS-1:0] dyn_ff;
	logic [7:0]             pview_ff;
	logic [7:0]             dview_ff;
	logic [SW-1:0]          sel_ff;
	logic                   cmd_ok_ff;
	boot_cfg_t              boot_cfg_ff;
	boot_state_t            boot_state_ff;
	logic [7:0]             dly_cnt_ff;
	logic                   aw_held_ff, w_held_ff;
	logic [7:0]             aw_addr_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;
	logic [7:0]             rd_addr_ff;
	logic                   pwd_mode;
	logic                   wr_fire;
	logic                   wr_reject;
	logic [31:0]            wr_word;
	logic [31:0]            rd_word;
	sector_cmd_t            cmd;
	logic                   cmd_fire;
	logic                   sect_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and hardware reset events

	// Two-flop capture of the reset and select pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hw_meta_ff <= 1'b1;
			hw_sync_ff <= 1'b1;
			hw_prev_ff <= 1'b1;
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
		end else begin
			hw_meta_ff <= hw_reset_n;
			hw_sync_ff <= hw_meta_ff;
			hw_prev_ff <= hw_sync_ff;
			cs_meta_ff <= boot_cs_n;
			cs_sync_ff <= cs_meta_ff;
		end
	end

	// Volatile state clears on either reset
	assign vol_rst    = !resetn || !hw_sync_ff;
	assign hw_release = hw_sync_ff && !hw_prev_ff;
	assign pwd_mode   = !option_ff[`POS_PWD_MODE];

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wr_word = merge(32'h0000_0000, w_data_ff, w_strb_ff);
	assign wr_reject = pwd_mode && ((aw_addr_ff == `OFS_PWD_LO) || (aw_addr_ff == `OFS_PWD_HI) ||
		(aw_addr_ff == `OFS_OPTION));
	assign cmd      = sector_cmd_t'({w_data_ff[`POS_CMD_LSB +: 3], w_data_ff[7:0]});
	assign cmd_fire = wr_fire && (aw_addr_ff == `OFS_CMD);
	assign sect_ok  = (cmd.sector < NUM_SECTORS);

	// Address and data taken in either order, answered once both are held
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h0000_0000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff    <= 1'b1;
				aw_addr_ff    <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff    <= 1'b1;
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (!mapped(aw_addr_ff) || wr_reject) ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Password, option and first config registers

	// Password store, locked in password mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pwd_ff <= `RST_PWD;
		end else if (wr_fire && !wr_reject) begin
			if (aw_addr_ff == `OFS_PWD_LO) begin
				pwd_ff[31:0] <= merge(pwd_ff[31:0], w_data_ff, w_strb_ff);
			end
			if (aw_addr_ff == `OFS_PWD_HI) begin
				pwd_ff[63:32] <= merge(pwd_ff[63:32], w_data_ff, w_strb_ff);
			end
		end
	end

	// Option register, locked in password mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			option_ff <= `RST_OPTION;
		end else if (wr_fire && !wr_reject && aw_addr_ff == `OFS_OPTION) begin
			option_ff <= 16'(merge({16'h0000, option_ff}, w_data_ff, w_strb_ff));
		end
	end

	// First config register, upper bits frozen in password mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg1_ff <= `RST_CFG1;
		end else if (wr_fire && aw_addr_ff == `OFS_CFG1 && w_strb_ff[0]) begin
			if (pwd_mode) begin
				cfg1_ff <= (cfg1_ff & `CFG1_LOCK_MASK) | (w_data_ff[7:0] & ~`CFG1_LOCK_MASK);
			end else begin
				cfg1_ff <= w_data_ff[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Guard bit and sector protection

	// Guard clears on a zero write and returns only through reset
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			guard_ff <= 1'b1;
		end else if (wr_fire && aw_addr_ff == `OFS_GUARD && w_strb_ff[0] &&
			!w_data_ff[`POS_GUARD]) begin
			guard_ff <= 1'b0;
		end
	end

	// Persistent bits, changed only while the guard is open
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pers_ff <= '1;
		end else if (cmd_fire && guard_ff) begin
			if (cmd.op == `CMD_PROG_PERS && sect_ok) begin
				pers_ff[cmd.sector[SW-1:0]] <= 1'b0;
			end
			if (cmd.op == `CMD_ERASE_PERS) begin
				pers_ff <= '1;
			end
		end
	end

	// Query sector and command outcome
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sel_ff    <= '0;
			cmd_ok_ff <= 1'b1;
		end else if (cmd_fire) begin
			if (sect_ok) begin
				sel_ff <= cmd.sector[SW-1:0];
			end
			cmd_ok_ff <= sect_ok && (guard_ff ||
				(cmd.op != `CMD_PROG_PERS && cmd.op != `CMD_ERASE_PERS));
		end
	end

	// Persistent view follows the last persistent query
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pview_ff <= `RST_VIEW;
		end else if (cmd_fire && cmd.op == `CMD_RD_PERS && sect_ok) begin
			pview_ff <= pers_ff[cmd.sector[SW-1:0]] ? `RST_VIEW : `VIEW_CLEAR;
		end
	end

	// Dynamic bits and view, volatile and writable
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			dyn_ff   <= '1;
			dview_ff <= `RST_VIEW;
		end else if (cmd_fire && cmd.op == `CMD_RD_DYN && sect_ok) begin
			dview_ff <= dyn_ff[cmd.sector[SW-1:0]] ? `RST_VIEW : `VIEW_CLEAR;
		end else if (wr_fire && aw_addr_ff == `OFS_DVIEW && w_strb_ff[0]) begin
			dyn_ff[sel_ff] <= |w_data_ff[7:0];
			dview_ff       <= (|w_data_ff[7:0]) ? `RST_VIEW : `VIEW_CLEAR;
		end
	end

	// Protect output, set where either bit protects
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sector_wp <= '0;
		end else begin
			sector_wp <= ~(pers_ff & dyn_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Boot read configuration and sequencer

	// Boot configuration word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			boot_cfg_ff <= boot_cfg_t'(`RST_BOOT);
		end else if (wr_fire && aw_addr_ff == `OFS_BOOT) begin
			boot_cfg_ff <= boot_cfg_t'(merge(32'(boot_cfg_ff), w_data_ff, w_strb_ff));
		end
	end

	// Arm on hardware reset release, delay, then stream ascending addresses
	always_ff @(posedge clk) begin
		if (!resetn) begin
			boot_state_ff <= BOOT_IDLE;
			dly_cnt_ff    <= 8'h00;
			boot_addr     <= 23'h000000;
			boot_valid    <= 1'b0;
		end else begin
			case (boot_state_ff)
				BOOT_IDLE: begin
					boot_valid <= 1'b0;
					if (hw_release && boot_cfg_ff.enable) begin
						boot_state_ff <= BOOT_ARMED;
					end
				end
				BOOT_ARMED: begin
					boot_addr  <= boot_cfg_ff.start_addr;
					dly_cnt_ff <= boot_cfg_ff.delay;
					if (!hw_sync_ff) begin
						boot_state_ff <= BOOT_IDLE;
					end else if (!cs_sync_ff) begin
						boot_state_ff <= (boot_cfg_ff.delay == 8'h00) ? BOOT_STREAM : BOOT_DELAY;
						boot_valid    <= (boot_cfg_ff.delay == 8'h00);
					end
				end
				BOOT_DELAY: begin
					if (cs_sync_ff || !hw_sync_ff) begin
						boot_state_ff <= BOOT_IDLE;
					end else if (dly_cnt_ff == 8'h01) begin
						boot_state_ff <= BOOT_STREAM;
						boot_valid    <= 1'b1;
					end else begin
						dly_cnt_ff <= dly_cnt_ff - 8'h01;
					end
				end
				BOOT_STREAM: begin
					if (cs_sync_ff || !hw_sync_ff) begin
						boot_state_ff <= BOOT_IDLE;
						boot_valid    <= 1'b0;
					end else begin
						boot_addr <= boot_addr + 23'h000001;
					end
				end
				default: begin
					boot_state_ff <= BOOT_IDLE;
					boot_valid    <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	// Read word select
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_addr_ff)
			`OFS_PWD_LO: rd_word = pwd_mode ? `PWD_MASKED : pwd_ff[31:0];
			`OFS_PWD_HI: rd_word = pwd_mode ? `PWD_MASKED : pwd_ff[63:32];
			`OFS_OPTION: rd_word = {16'h0000, option_ff};
			`OFS_CFG1:   rd_word = {24'h000000, cfg1_ff};
			`OFS_GUARD:  rd_word = {31'h00000000, guard_ff};
			`OFS_PVIEW:  rd_word = {24'h000000, pview_ff};
			`OFS_DVIEW:  rd_word = {24'h000000, dview_ff};
			`OFS_CMD:    rd_word = {15'h0000, cmd_ok_ff, 8'h00, 8'(sel_ff)};
			`OFS_BOOT:   rd_word = 32'(boot_cfg_ff);
			default:     rd_word = 32'h0000_0000;
		endcase
	end

	// Address taken, data returned on the following edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_addr_ff    <= 8'h00;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_ff    <= {s_axi_araddr[7:2], 2'b00};
			s_axi_arready <= 1'b0;
		end else if (!s_axi_arready && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= mapped(rd_addr_ff) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_pwd_masked: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s_axi_rvalid) && pwd_mode && (rd_addr_ff == `OFS_PWD_LO || rd_addr_ff == `OFS_PWD_HI)
		|-> s_axi_rdata == `PWD_MASKED)
		else $error("password readable in password mode");

	a_guard_sticky: assert property (@(posedge clk) disable iff (vol_rst)
		!guard_ff |=> !guard_ff)
		else $error("guard reopened without reset");

	a_pers_frozen: assert property (@(posedge clk) disable iff (!resetn)
		!guard_ff |=> $stable(pers_ff))
		else $error("persistent bits changed under guard");

	a_guard_rsvd: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s_axi_rvalid) && rd_addr_ff == `OFS_GUARD |-> s_axi_rdata[31:1] == 31'h00000000)
		else $error("guard reserved bits not zero");

	a_pview_code: assert property (@(posedge clk) disable iff (!resetn)
		$past(cmd_fire && cmd.op == `CMD_RD_PERS && sect_ok)
		|-> pview_ff == ($past(pers_ff[cmd.sector[SW-1:0]]) ? `RST_VIEW : `VIEW_CLEAR))
		else $error("persistent view mismatch");

	a_dview_code: assert property (@(posedge clk) disable iff (!resetn)
		$past(cmd_fire && cmd.op == `CMD_RD_DYN && sect_ok && !vol_rst)
		|-> dview_ff == ($past(dyn_ff[cmd.sector[SW-1:0]]) ? `RST_VIEW : `VIEW_CLEAR))
		else $error("dynamic view mismatch");

	a_dview_reset: assert property (@(posedge clk)
		!hw_sync_ff ##1 hw_sync_ff |-> dview_ff == `RST_VIEW && dyn_ff == '1)
		else $error("dynamic state not restored by reset");

	a_boot_off: assert property (@(posedge clk) disable iff (!resetn)
		boot_state_ff == BOOT_IDLE && !boot_cfg_ff.enable |=> boot_state_ff == BOOT_IDLE)
		else $error("boot read left idle while disabled");

	a_boot_delay: assert property (@(posedge clk) disable iff (!resetn)
		boot_state_ff == BOOT_ARMED && hw_sync_ff && !cs_sync_ff && boot_cfg_ff.delay == 8'h02
		##1 (!cs_sync_ff && hw_sync_ff)[*2] |-> !boot_valid ##1 boot_valid)
		else $error("boot delay count wrong");

	a_boot_incr: assert property (@(posedge clk) disable iff (!resetn)
		boot_valid && $past(boot_valid) |-> boot_addr == $past(boot_addr) + 23'h000001)
		else $error("boot address not ascending");

	a_pwd_lock: assert property (@(posedge clk) disable iff (!resetn)
		wr_fire && wr_reject |=> $stable(pwd_ff) && $stable(option_ff) && s_axi_bresp == `RESP_SLVERR)
		else $error("locked write took effect");

endmodule
`default_nettype wire

/* File: testbench/host_boot_model.sv */
// Host side model: drives the reset and select pins and follows the boot stream
`timescale 1ns/1ps
`default_nettype none
module host_boot_model (
	input  wire logic        clk,        // Bench clock
	output logic             hw_reset_n, // Hardware reset pin
	output logic             boot_cs_n,  // Chip select, pulled up
	input  wire logic [22:0] boot_addr,  // Boot byte address
	input  wire logic        boot_valid  // Boot address valid
);
	// Pins idle released
	initial begin
		hw_reset_n = 1'b1;
		boot_cs_n  = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Reset pulse long enough for the synchroniser
	task automatic hw_pulse();
		hw_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		hw_reset_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
	// Reset, select, then follow n boot bytes
	task automatic boot_frame(input int n, output int lat, output logic [22:0] first,
		output logic ok);
		logic [22:0] prev;
		hw_pulse();
		boot_cs_n <= 1'b0;
		lat = -1;
		ok = 1'b1;
		for (int i = 1; i <= 40 && lat < 0; i++) begin
			@(posedge clk);
			if (boot_valid === 1'b1) lat = i;
		end
		prev = boot_addr;
		first = prev;
		// Select held low for the whole run
		for (int k = 1; k < n && lat > 0; k++) begin
			@(posedge clk);
			if (boot_valid !== 1'b1 || boot_addr !== prev + 23'h1) ok = 1'b0;
			prev = boot_addr;
		end
		boot_cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the protection and boot register block
`timescale 1ns/1ps
`default_nettype none
`include "prot_boot_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
	import prot_boot_pkg::*;
	logic        clk, resetn, hw_reset_n, boot_cs_n, boot_valid;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [22:0] boot_addr, start, first;
	logic [15:0] sector_wp;
	logic [63:0] pwd;
	logic        ok;
	int          fails, samples_checked, lat_a, lat_b;
	logic [1:0]  wq[$];
	logic [33:0] rq[$];
	logic [1:0]  exp_b;
	logic [33:0] exp_r;
	////////////////////////////////////////////////////////////////////////////////
	prot_boot_regs #(.NUM_SECTORS(16)) uut (
		.clk(clk), .resetn(resetn), .hw_reset_n(hw_reset_n), .boot_cs_n(boot_cs_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .boot_addr(boot_addr),
		.boot_valid(boot_valid), .sector_wp(sector_wp));
	host_boot_model host (.clk(clk), .hw_reset_n(hw_reset_n), .boot_cs_n(boot_cs_n),
		.boot_addr(boot_addr), .boot_valid(boot_valid));
	// Clock
	always #5 clk = ~clk;
	// Response monitor takes the oldest note
	always @(posedge clk) begin
		if (bvalid === 1'b1 && bready === 1'b1) begin
			exp_b = wq.pop_front();
			`CHK("bresp", exp_b, bresp)
		end
		if (rvalid === 1'b1 && rready === 1'b1) begin
			exp_r = rq.pop_front();
			`CHK("rdata", exp_r, {rresp, rdata})
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Write cycle, address and data together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
		logic aw_done, w_done;
		wq.push_back(r);
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
	endtask
	// Read cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
	endtask
	// Sector command word
	function automatic logic [31:0] cmdw(input logic [2:0] op, input logic [7:0] sec);
		return {21'h0, op, sec};
	endfunction
	// Verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#200000;
		fails++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{clk, resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		void'($urandom(93));
		pwd = {$urandom, $urandom};
		start = 23'($urandom);
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(`OFS_PWD_LO, 32'hFFFF_FFFF);
		rd(`OFS_GUARD, 32'h1);
		rd(`OFS_PVIEW, 32'hFF);
		rd(`OFS_DVIEW, 32'hFF);
		rd(`OFS_BOOT, 32'h0);
		rd(8'h40, 32'h0, `RESP_SLVERR);
		wr(8'h40, 32'h1, `RESP_SLVERR);
		wr(`OFS_PWD_LO, pwd[31:0]);
		wr(`OFS_PWD_HI, pwd[63:32]);
		rd(`OFS_PWD_LO, pwd[31:0]);
		rd(`OFS_PWD_HI, pwd[63:32]);
		// Persistent bits and the guard
		wr(`OFS_CMD, cmdw(`CMD_PROG_PERS, 8'h3));
		wr(`OFS_CMD, cmdw(`CMD_RD_PERS, 8'h3));
		rd(`OFS_PVIEW, 32'h0);
		`CHK("sector_wp3", 1'b1, sector_wp[3])
		wr(`OFS_CMD, cmdw(`CMD_RD_PERS, 8'h4));
		rd(`OFS_PVIEW, 32'hFF);
		wr(`OFS_GUARD, 32'h0);
		rd(`OFS_GUARD, 32'h0);
		wr(`OFS_CMD, cmdw(`CMD_ERASE_PERS, 8'h3));
		wr(`OFS_CMD, cmdw(`CMD_RD_PERS, 8'h3));
		rd(`OFS_PVIEW, 32'h0);
		// Dynamic bits
		wr(`OFS_CMD, cmdw(`CMD_RD_DYN, 8'h5));
		rd(`OFS_DVIEW, 32'hFF);
		wr(`OFS_DVIEW, 32'h0);
		rd(`OFS_DVIEW, 32'h0);
		wr(`OFS_CMD, cmdw(`CMD_RD_DYN, 8'h6));
		rd(`OFS_DVIEW, 32'hFF);
		wr(`OFS_CMD, cmdw(`CMD_RD_DYN, 8'h5));
		rd(`OFS_DVIEW, 32'h0);
		// Hardware reset restores volatile state
		host.hw_pulse();
		rd(`OFS_GUARD, 32'h1);
		wr(`OFS_CMD, cmdw(`CMD_RD_DYN, 8'h5));
		rd(`OFS_DVIEW, 32'hFF);
		wr(`OFS_CMD, cmdw(`CMD_ERASE_PERS, 8'h3));
		wr(`OFS_CMD, cmdw(`CMD_RD_PERS, 8'h3));
		rd(`OFS_PVIEW, 32'hFF);
		// Boot read, off then delays 0, 4 and 2
		wr(`OFS_BOOT, {start, 8'h00, 1'b0});
		host.boot_frame(8, lat_a, first, ok);
		`CHK("boot_off", -1, lat_a)
		wr(`OFS_BOOT, {start, 8'h00, 1'b1});
		host.boot_frame(8, lat_a, first, ok);
		`CHK("boot_start", start, first)
		`CHK("boot_seq", 1'b1, ok)
		wr(`OFS_BOOT, {start, 8'h04, 1'b1});
		rd(`OFS_BOOT, {start, 8'h04, 1'b1});
		host.boot_frame(8, lat_b, first, ok);
		`CHK("boot_delay", 4, lat_b - lat_a)
		wr(`OFS_BOOT, {start, 8'h02, 1'b1});
		host.boot_frame(8, lat_b, first, ok);
		`CHK("boot_delay2", 2, lat_b - lat_a)
		// Password mode
		wr(`OFS_OPTION, 32'h0000_FFFB);
		rd(`OFS_OPTION, 32'h0000_FFFB);
		rd(`OFS_PWD_HI, `PWD_MASKED);
		wr(`OFS_PWD_LO, 32'h1, `RESP_SLVERR);
		wr(`OFS_OPTION, 32'h0000_FFFF, `RESP_SLVERR);
		rd(`OFS_OPTION, 32'h0000_FFFB);
		wr(`OFS_CFG1, 32'hFF);
		rd(`OFS_CFG1, 32'h03);
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule
`default_nettype wire
